// >>> hw/cim_ctrl.sv
// CAN controller event flags, event enables and mode control with an Avalon-MM slave
`include "cim_defs.svh"

module cim_ctrl (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [7:0] avs_writedata_i,
	output logic [7:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Events from the protocol engine, same clock
	input wire logic bus_error_i,
	input wire logic arb_lost_i,
	input wire logic [8:0] rx_err_count_i,
	input wire logic [8:0] tx_err_count_i,
	input wire logic bus_status_i,
	input wire logic error_status_i,
	input wire logic tx_buf_status_i,
	input wire logic overrun_status_i,
	input wire logic rx_msg_avail_i,
	input wire logic rx_more_msgs_i,
	input wire logic bus_active_i,
	// Pin side bus activity, asynchronous
	input wire logic rx_pin_i,
	// Interrupt, mode outputs and receive release strobe
	output logic irq_o,
	output logic single_filter_o,
	output logic ack_ok_wo_ack_o,
	output logic ack_drive_en_o,
	output logic frame_abort_o,
	output logic reset_mode_o,
	output logic sleeping_o,
	output logic rx_release_o
);

	// ==========================================
	// State
	// ==========================================
	logic [7:0] event_flag_reg;
	logic [7:0] event_enable_reg;
	logic [4:0] operating_control_reg;
	cim_pkg::cim_mode_t mode;
	logic [7:0] next_flags;
	logic [7:0] set_vec;
	logic rx_meta;
	logic rx_sync;
	logic rx_sync_d;
	logic bus_st_d;
	logic err_st_d;
	logic txbuf_d;
	logic ovr_d;
	logic passive_d;
	logic passive_now;
	logic ack_phase;
	logic wr_stb;
	logic rd_stb;
	logic flags_read;
	logic release_cmd;
	logic sleep_wr;
	logic sleep_val;
	logic reset_wr;

	// ==========================================
	// Bus decode, one wait state on reads
	// ==========================================
	assign wr_stb = avs_write_i;
	assign rd_stb = avs_read_i && ack_phase;
	assign avs_waitrequest_o = avs_read_i && !ack_phase;
	assign flags_read = rd_stb && (avs_address_i == `CIM_IDX_FLAGS);
	assign release_cmd = wr_stb && (avs_address_i == `CIM_IDX_CMD) && avs_writedata_i[`CIM_CMD_RELEASE];
	assign sleep_wr = wr_stb && (avs_address_i == `CIM_IDX_OPCTL) && (mode != cim_pkg::CIM_RESET);
	assign sleep_val = avs_writedata_i[`CIM_MOD_SLEEP];
	assign reset_wr = wr_stb && (avs_address_i == `CIM_IDX_OPCTL);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_phase <= 1'b0;
		end else begin
			ack_phase <= avs_read_i && !ack_phase;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata_o <= `CIM_BYTE_ZERO;
		end else if (avs_read_i && !ack_phase) begin
			unique case (avs_address_i)
				`CIM_IDX_OPCTL: avs_readdata_o <= {3'h0, operating_control_reg};
				`CIM_IDX_STATUS: avs_readdata_o <= {bus_status_i, error_status_i, 3'h0,
					tx_buf_status_i, overrun_status_i, rx_msg_avail_i};
				`CIM_IDX_FLAGS: avs_readdata_o <= event_flag_reg;
				`CIM_IDX_ENABLES: avs_readdata_o <= event_enable_reg;
				`CIM_IDX_MODE_STAT: avs_readdata_o <= {6'h00, mode};
				default: avs_readdata_o <= `CIM_BYTE_ZERO;
			endcase
		end
	end

	// ==========================================
	// Pin synchroniser and edge history
	// ==========================================
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			rx_sync_d <= 1'b1;
		end else begin
			rx_meta <= rx_pin_i;
			rx_sync <= rx_meta;
			rx_sync_d <= rx_sync;
		end
	end

	assign passive_now = (rx_err_count_i > `CIM_PASSIVE_LIMIT) || (tx_err_count_i > `CIM_PASSIVE_LIMIT);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_st_d <= 1'b0;
			err_st_d <= 1'b0;
			txbuf_d <= 1'b1;
			ovr_d <= 1'b0;
			passive_d <= 1'b0;
		end else begin
			bus_st_d <= bus_status_i;
			err_st_d <= error_status_i;
			txbuf_d <= tx_buf_status_i;
			ovr_d <= overrun_status_i;
			passive_d <= passive_now;
		end
	end

	// ==========================================
	// Event enables
	// ==========================================
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_enable_reg <= `CIM_BYTE_ZERO;
		end else if (wr_stb && avs_address_i == `CIM_IDX_ENABLES) begin
			event_enable_reg <= avs_writedata_i;
		end
	end

	// ==========================================
	// Event flags
	// ==========================================
	always_comb begin
		set_vec = `CIM_BYTE_ZERO;
		set_vec[`CIM_BIT_BUS_ERR] = bus_error_i;
		set_vec[`CIM_BIT_ARB_LOST] = arb_lost_i;
		set_vec[`CIM_BIT_PASSIVE] = passive_now != passive_d;
		set_vec[`CIM_BIT_WAKEUP] = (mode == cim_pkg::CIM_SLEEP) && (bus_active_i || (rx_sync_d && !rx_sync));
		set_vec[`CIM_BIT_OVERRUN] = overrun_status_i && !ovr_d;
		set_vec[`CIM_BIT_WARNING] = (bus_status_i != bus_st_d) || (error_status_i != err_st_d);
		set_vec[`CIM_BIT_TX_DONE] = tx_buf_status_i && !txbuf_d;
		set_vec[`CIM_BIT_RX_PEND] = 1'b0;
		set_vec = set_vec & event_enable_reg;
	end

	genvar gi;
	generate
		for (gi = 1; gi < 8; gi++) begin : g_flag
			// Hardware set wins over the read clear
			assign next_flags[gi] = set_vec[gi] || (event_flag_reg[gi] && !flags_read);
		end
	endgenerate
	// Receive pending tracks buffer contents; release with nothing left clears it
	assign next_flags[`CIM_BIT_RX_PEND] = event_enable_reg[`CIM_BIT_RX_PEND] && rx_msg_avail_i
		&& !(release_cmd && !rx_more_msgs_i);

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			event_flag_reg <= `CIM_BYTE_ZERO;
		end else begin
			event_flag_reg <= next_flags;
		end
	end

	assign irq_o = |event_flag_reg;
	assign rx_release_o = release_cmd;

	// ==========================================
	// Mode register and controller mode
	// ==========================================
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			operating_control_reg <= `CIM_OPCTL_RESET;
		end else if (reset_wr) begin
			operating_control_reg[`CIM_MOD_SINGLE] <= avs_writedata_i[`CIM_MOD_SINGLE];
			operating_control_reg[`CIM_MOD_SELFTEST] <= avs_writedata_i[`CIM_MOD_SELFTEST];
			operating_control_reg[`CIM_MOD_LISTEN] <= avs_writedata_i[`CIM_MOD_LISTEN];
			operating_control_reg[`CIM_MOD_RESET] <= avs_writedata_i[`CIM_MOD_RESET];
			if (sleep_wr) begin
				// Refused sleep falls back to wake-up
				operating_control_reg[`CIM_MOD_SLEEP] <= sleep_val && !irq_o && !bus_active_i;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode <= cim_pkg::CIM_RESET;
		end else begin
			unique case (mode)
				cim_pkg::CIM_RESET: begin
					if (reset_wr && !avs_writedata_i[`CIM_MOD_RESET]) begin
						mode <= cim_pkg::CIM_OPERATE;
					end
				end
				cim_pkg::CIM_OPERATE: begin
					if (reset_wr && avs_writedata_i[`CIM_MOD_RESET]) begin
						mode <= cim_pkg::CIM_RESET;
					end else if (sleep_wr && sleep_val && !irq_o && !bus_active_i) begin
						mode <= cim_pkg::CIM_SLEEP;
					end
				end
				cim_pkg::CIM_SLEEP: begin
					if (reset_wr && avs_writedata_i[`CIM_MOD_RESET]) begin
						mode <= cim_pkg::CIM_RESET;
					end else if ((sleep_wr && !sleep_val) || set_vec[`CIM_BIT_WAKEUP]
						|| bus_active_i) begin
						mode <= cim_pkg::CIM_OPERATE;
					end
				end
				default: mode <= cim_pkg::CIM_RESET;
			endcase
		end
	end

	// ==========================================
	// Mode outputs
	// ==========================================
	assign reset_mode_o = (mode == cim_pkg::CIM_RESET);
	assign sleeping_o = (mode == cim_pkg::CIM_SLEEP);
	assign frame_abort_o = reset_wr && avs_writedata_i[`CIM_MOD_RESET] && !reset_mode_o;
	assign single_filter_o = operating_control_reg[`CIM_MOD_SINGLE];
	assign ack_ok_wo_ack_o = operating_control_reg[`CIM_MOD_SELFTEST];
	assign ack_drive_en_o = !operating_control_reg[`CIM_MOD_LISTEN] && !reset_mode_o;

	// ==========================================
	// Assertions
	// ==========================================
	irq_follows_flags_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(irq_o == (event_flag_reg != 8'h00))) else $error("irq does not follow flags");
	read_clears_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		flags_read && !bus_error_i |=> !event_flag_reg[7]) else $error("bus error flag not cleared by read");
	bus_err_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		bus_error_i && event_enable_reg[7] |=> event_flag_reg[7]) else $error("bus error flag not set");
	arb_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!event_enable_reg[6] && !event_flag_reg[6] |=> !event_flag_reg[6]) else $error("arb flag set while disabled");
	overrun_edge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(overrun_status_i) && event_enable_reg[3] |=> event_flag_reg[3]) else $error("overrun flag missed");
	warning_change_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$changed(error_status_i) && event_enable_reg[2] |=> event_flag_reg[2]) else $error("warning flag missed");
	rx_pend_track_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		rx_msg_avail_i && event_enable_reg[0] && !release_cmd |=> event_flag_reg[0]) else $error("rx pending lost");
	mode_read_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		avs_read_i && !ack_phase && avs_address_i == 4'h0 |=> avs_readdata_o[7:5] == 3'h0)
		else $error("reserved mode bits nonzero");
	reset_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_wr && avs_writedata_i[0] |=> reset_mode_o) else $error("reset mode not entered");
	listen_ack_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		operating_control_reg[1] |-> !ack_drive_en_o) else $error("ack driven in listen only");

	passive_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(passive_now != passive_d) && event_enable_reg[`CIM_BIT_PASSIVE]
		|=> event_flag_reg[`CIM_BIT_PASSIVE])
		else $error("passive change flag missed");
	wake_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cim_pkg::CIM_SLEEP) && bus_active_i && event_enable_reg[`CIM_BIT_WAKEUP]
		|=> event_flag_reg[`CIM_BIT_WAKEUP])
		else $error("wakeup flag missed");
	tx_done_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$rose(tx_buf_status_i) && event_enable_reg[`CIM_BIT_TX_DONE]
		|=> event_flag_reg[`CIM_BIT_TX_DONE])
		else $error("transmit done flag missed");
	rx_release_clr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		release_cmd && !rx_more_msgs_i
		|=> !event_flag_reg[`CIM_BIT_RX_PEND])
		else $error("receive pending not cleared by release");
	rx_pend_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!event_enable_reg[`CIM_BIT_RX_PEND]
		|=> !event_flag_reg[`CIM_BIT_RX_PEND])
		else $error("receive pending set while disabled");
	enable_write_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		wr_stb && (avs_address_i == `CIM_IDX_ENABLES)
		|=> event_enable_reg == $past(avs_writedata_i))
		else $error("enable register write lost");
	sleep_refuse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		sleep_wr && sleep_val && (irq_o || bus_active_i)
		|=> !operating_control_reg[`CIM_MOD_SLEEP])
		else $error("sleep accepted while busy");
	sleep_entry_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cim_pkg::CIM_OPERATE) && sleep_wr && sleep_val && !irq_o && !bus_active_i
		&& !avs_writedata_i[`CIM_MOD_RESET] |=> sleeping_o)
		else $error("sleep not entered");
	sleep_lock_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_wr && (mode == cim_pkg::CIM_RESET)
		|=> operating_control_reg[`CIM_MOD_SLEEP] == $past(operating_control_reg[`CIM_MOD_SLEEP]))
		else $error("sleep bit written in reset mode");
	wake_clear_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(mode == cim_pkg::CIM_SLEEP) && sleep_wr && !sleep_val
		|=> !sleeping_o)
		else $error("clearing sleep did not wake");
	filter_sel_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_wr
		|=> single_filter_o == $past(avs_writedata_i[`CIM_MOD_SINGLE]))
		else $error("filter select not stored");
	self_test_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_wr
		|=> ack_ok_wo_ack_o == $past(avs_writedata_i[`CIM_MOD_SELFTEST]))
		else $error("self test bit not stored");
	abort_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_wr && avs_writedata_i[`CIM_MOD_RESET] && !reset_mode_o
		|-> frame_abort_o)
		else $error("frame abort missing");
	reset_exit_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		reset_mode_o && reset_wr && !avs_writedata_i[`CIM_MOD_RESET]
		|=> !reset_mode_o)
		else $error("reset mode not left");
	irq_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		(event_flag_reg == `CIM_BYTE_ZERO)
		|-> !irq_o)
		else $error("irq high with no flag");
	arb_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		arb_lost_i && event_enable_reg[`CIM_BIT_ARB_LOST]
		|=> event_flag_reg[`CIM_BIT_ARB_LOST])
		else $error("arbitration flag missed");
	warn_bus_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		$changed(bus_status_i) && event_enable_reg[`CIM_BIT_WARNING]
		|=> event_flag_reg[`CIM_BIT_WARNING])
		else $error("warning flag missed on bus status");
	overrun_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!event_enable_reg[`CIM_BIT_OVERRUN] && !event_flag_reg[`CIM_BIT_OVERRUN]
		|=> !event_flag_reg[`CIM_BIT_OVERRUN])
		else $error("overrun flag set while disabled");
	rx_keep_read_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		flags_read && rx_msg_avail_i && event_enable_reg[`CIM_BIT_RX_PEND] && !release_cmd
		|=> event_flag_reg[`CIM_BIT_RX_PEND])
		else $error("receive pending cleared by read");
	bus_err_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
		!event_enable_reg[`CIM_BIT_BUS_ERR] && !event_flag_reg[`CIM_BIT_BUS_ERR]
		|=> !event_flag_reg[`CIM_BIT_BUS_ERR])
		else $error("bus error flag set while disabled");

endmodule : cim_ctrl

// >>> hw/cim_defs.svh
// Register offsets, field positions and reset values of the CAN event and mode block
`ifndef CIM_DEFS_SVH
`define CIM_DEFS_SVH

// ==========================================
// Register indices and byte addresses
// ==========================================
`define CIM_IDX_OPCTL 4'h0
`define CIM_IDX_CMD 4'h1
`define CIM_IDX_STATUS 4'h2
`define CIM_IDX_FLAGS 4'h3
`define CIM_IDX_ENABLES 4'h4
`define CIM_IDX_MODE_STAT 4'h5

// ==========================================
// Field positions
// ==========================================
`define CIM_BIT_BUS_ERR 3'h7
`define CIM_BIT_ARB_LOST 3'h6
`define CIM_BIT_PASSIVE 3'h5
`define CIM_BIT_WAKEUP 3'h4
`define CIM_BIT_OVERRUN 3'h3
`define CIM_BIT_WARNING 3'h2
`define CIM_BIT_TX_DONE 3'h1
`define CIM_BIT_RX_PEND 3'h0

`define CIM_MOD_SLEEP 3'h4
`define CIM_MOD_SINGLE 3'h3
`define CIM_MOD_SELFTEST 3'h2
`define CIM_MOD_LISTEN 3'h1
`define CIM_MOD_RESET 3'h0

`define CIM_ST_BUS 3'h7
`define CIM_ST_ERR 3'h6
`define CIM_ST_TXBUF 3'h2
`define CIM_ST_OVERRUN 3'h1

`define CIM_CMD_RELEASE 3'h2

// ==========================================
// Widths and reset values
// ==========================================
`define CIM_MOD_USED_W 5
`define CIM_PASSIVE_LIMIT 9'h07F
`define CIM_OPCTL_RESET 5'h01
`define CIM_BYTE_ZERO 8'h00

`endif

// >>> hw/cim_pkg.sv
// Types shared by the CAN event and mode block
package cim_pkg;

	// ==========================================
	// Controller mode
	// ==========================================
	typedef enum logic [1:0] {
		CIM_RESET = 2'b00,
		CIM_OPERATE = 2'b01,
		CIM_SLEEP = 2'b10
	} cim_mode_t;

endpackage : cim_pkg

// >>> verification/cim_ctrl_tb_top.sv
// Self-checking testbench of the CAN event and mode block
module cim_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Signals
	// ==========================================
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [3:0] avs_address_i = 4'h0;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [7:0] avs_writedata_i = 8'h00;
	logic [3:0] cmd = 4'h0;
	logic [7:0] avs_readdata_o, st, en, q;
	logic avs_waitrequest_o, irq_o, single_filter_o, ack_ok_wo_ack_o, ack_drive_en_o;
	logic frame_abort_o, reset_mode_o, sleeping_o, rx_release_o, bus_error, arb_lost, bus_active, rx_pin;
	logic [8:0] tx_err;
	logic [7:0] tbl [2][7] = '{'{8'h80, 8'h40, 8'h20, 8'h08, 8'h04, 8'h04, 8'h02},
		'{8'h80, 8'h40, 8'h20, 8'h00, 8'h04, 8'h04, 8'h00}};
	int failures = 0;
	int checked = 0;
	int mflags;

	always #10 sys_clk_i = ~sys_clk_i;

	cim_ctrl uut (.sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
		.avs_readdata_o, .avs_waitrequest_o, .bus_error_i(bus_error), .arb_lost_i(arb_lost),
		.rx_err_count_i(9'h000), .tx_err_count_i(tx_err), .bus_status_i(st[7]), .error_status_i(st[6]),
		.tx_buf_status_i(st[2]), .overrun_status_i(st[1]), .rx_msg_avail_i(st[0]), .rx_more_msgs_i(st[3]),
		.bus_active_i(bus_active), .rx_pin_i(rx_pin), .irq_o, .single_filter_o, .ack_ok_wo_ack_o,
		.ack_drive_en_o, .frame_abort_o, .reset_mode_o, .sleeping_o, .rx_release_o);

	cim_far_model far (.sys_clk_i, .rst_n_i, .cmd_i(cmd), .rx_release_i(rx_release_o), .bus_error_o(bus_error),
		.arb_lost_o(arb_lost), .tx_err_o(tx_err), .st_o(st), .bus_active_o(bus_active), .rx_pin_o(rx_pin));

	// ==========================================
	// Tasks
	// ==========================================
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		checked++;
		if (g !== x) begin
			$display("Error %s expected %h seen %h", n, x, g);
			failures++;
		end
	endtask : chk

	task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk_i);
		avs_read_i <= rd;
		avs_write_i <= !rd;
		avs_address_i <= a;
		avs_writedata_i <= d;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 20);
		if (avs_waitrequest_o !== 1'b0) begin
			failures++;
			complete_run();
		end
		q = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [7:0] x, input string n);
		bus(1'b1, a, 8'h00);
		chk(n, x, q);
	endtask : rd

	task automatic fire(input logic [3:0] c);
		@(posedge sys_clk_i);
		cmd <= c;
		@(posedge sys_clk_i);
		cmd <= 4'h0;
		repeat (6) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : fire

	// ==========================================
	// Main sequence
	// ==========================================
	initial begin
		en = 8'($urandom(91));
		repeat (2) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		rd(4'h0, 8'h01, "mode");
		rd(4'h4, 8'h00, "enables");
		bus(1'b0, 4'h9, 8'hFF);
		rd(4'h9, 8'h00, "unmapped");
		$display("Test reset done");
		bus(1'b0, 4'h0, 8'hF1);
		rd(4'h0, 8'h01, "mode");
		bus(1'b0, 4'h0, 8'h0E);
		@(negedge sys_clk_i);
		chk("mode_out", 8'h06, {4'h0, reset_mode_o, single_filter_o, ack_ok_wo_ack_o, ack_drive_en_o});
		bus(1'b0, 4'h0, 8'h00);
		@(negedge sys_clk_i);
		chk("mode_out", 8'h01, {4'h0, reset_mode_o, single_filter_o, ack_ok_wo_ack_o, ack_drive_en_o});
		$display("Test mode bits done");
		for (int r = 0; r < 2; r++) begin
			for (int c = 1; c < 8; c++) begin
				en = 8'($urandom);
				bus(1'b0, 4'h4, en);
				rd(4'h4, en, "enables");
				fire(4'(c));
				mflags = tbl[r][c - 1] & en;
				chk("irq", 8'(mflags != 0), {7'h00, irq_o});
				rd(4'h3, 8'(mflags), "flags");
				rd(4'h3, 8'h00, "flags");
				@(negedge sys_clk_i);
				chk("irq", 8'h00, {7'h00, irq_o});
			end
		end
		$display("Test events done");
		bus(1'b0, 4'h4, 8'h01);
		fire(4'h8);
		rd(4'h3, 8'h01, "flags");
		rd(4'h3, 8'h01, "flags");
		fire(4'h9);
		bus(1'b0, 4'h1, 8'h04);
		rd(4'h3, 8'h01, "flags");
		bus(1'b0, 4'h1, 8'h04);
		rd(4'h3, 8'h00, "flags");
		$display("Test receive done");
		bus(1'b0, 4'h4, 8'h90);
		bus(1'b0, 4'h0, 8'h10);
		rd(4'h5, 8'h02, "state");
		chk("sleeping", 8'h01, {7'h00, sleeping_o});
		fire(4'hA);
		rd(4'h3, 8'h10, "flags");
		bus(1'b0, 4'h0, 8'h00);
		bus(1'b0, 4'h0, 8'h10);
		bus(1'b0, 4'h0, 8'h00);
		rd(4'h5, 8'h01, "state");
		fire(4'h1);
		bus(1'b0, 4'h0, 8'h10);
		rd(4'h0, 8'h00, "mode");
		rd(4'h3, 8'h80, "flags");
		$display("Test sleep done");
		bus(1'b0, 4'h0, 8'h01);
		rd(4'h5, 8'h00, "state");
		$display("Test reset mode done");
		complete_run();
	end
endmodule : cim_ctrl_tb_top

// >>> verification/cim_far_model.sv
// Far side model: protocol engine status levels, events and the CAN receive pin
module cim_far_model (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Bench commands and release strobe
	input wire logic [3:0] cmd_i,
	input wire logic rx_release_i,
	// Engine side
	output logic bus_error_o,
	output logic arb_lost_o,
	output logic [8:0] tx_err_o,
	output logic [7:0] st_o,
	output logic bus_active_o,
	output logic rx_pin_o
);
	logic [1:0] act_cnt;

	// ==========================================
	// Status levels, pulses and bus activity
	// ==========================================
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_error_o <= 1'b0;
			arb_lost_o <= 1'b0;
			tx_err_o <= 9'h000;
			st_o <= 8'h00;
			act_cnt <= 2'h0;
		end else begin
			bus_error_o <= (cmd_i == 4'h1);
			arb_lost_o <= (cmd_i == 4'h2);
			if (act_cnt != 2'h0) act_cnt <= act_cnt - 2'h1;
			case (cmd_i)
				4'h3: tx_err_o <= (tx_err_o > 9'h07F) ? 9'h07F : 9'h080;
				4'h4: st_o[1] <= ~st_o[1];
				4'h5: st_o[7] <= ~st_o[7];
				4'h6: st_o[6] <= ~st_o[6];
				4'h7: st_o[2] <= ~st_o[2];
				4'h8: st_o[0] <= 1'b1;
				4'h9: st_o[3] <= 1'b1;
				4'hA: act_cnt <= 2'h3;
				default: ;
			endcase
			if (rx_release_i) begin
				st_o[0] <= st_o[3];
				st_o[3] <= 1'b0;
			end
		end
	end

	// Receive pin idles recessive high
	assign bus_active_o = (act_cnt != 2'h0);
	assign rx_pin_o = (act_cnt == 2'h0);
endmodule : cim_far_model
